/* File: rtl/sar_ctrl.sv */
// conversion sequencer and parallel/serial result readout
`timescale 1ns/1ps
module sar_ctrl (
    input  wire logic           clk_sys,
    input  wire logic           rst_n,
    input  wire logic           convert_start_n,
    input  wire logic           cs_n,
    input  wire logic           rd_n,
    input  wire logic           sclk_in,
    input  wire sar_pkg::cfg_s  cfg,
    input  wire logic [17:0]    sample_code,
    output sar_pkg::out_s       out
);
    typedef struct packed {
        sar_pkg::phase_e ph;
        logic [7:0]      cnt;
        logic            cnv_prev;
        logic [17:0]     result;
        logic [17:0]     shreg;
        logic [4:0]      bits;
        logic            sending;
        logic            sclk_int;
        logic [3:0]      div;
        logic            sclk_prev;
        logic            chain_bit;
        sar_pkg::out_s   o;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic serial;
    logic master;
    logic ext_rise;
    logic ext_fall;
    logic rd_on;
    logic [17:0] coded;

    assign serial = cfg.interface_mode_sel_lo & cfg.interface_mode_sel_hi;
    assign master = serial & ~cfg.clock_source_select;
    assign rd_on = ~cs_n & ~rd_n;
    // external clock gated by chip-select and read; any idle level works since only edges count
    assign ext_rise = rd_on & sclk_in & ~s_q.sclk_prev;
    assign ext_fall = rd_on & ~sclk_in & s_q.sclk_prev;

    always_comb
    begin
        // msb flip gives twos complement; not in 18-bit parallel
        if (!cfg.output_coding_select && !(!serial && cfg.interface_mode_sel_hi == 1'b0
            && cfg.interface_mode_sel_lo == 1'b0))
            coded = {~sample_code[17], sample_code[16:0]};
        else
            coded = sample_code;
    end

    always_comb
    begin
        logic start;
        logic conv_done;
        logic [1:0] bm;
        start = 1'b0;
        conv_done = 1'b0;
        bm = {cfg.interface_mode_sel_hi, cfg.interface_mode_sel_lo};
        s_d = s_q;
        s_d.cnv_prev = convert_start_n;
        s_d.sclk_prev = sclk_in;
        s_d.o.read_overrun_flag = 1'b0;
        // falling edge of convert-start, independent of the read strobes
        start = s_q.cnv_prev & ~convert_start_n;
        s_d.o.ref_buf_on = ~cfg.ref_buffer_powerdown;
        unique case (s_q.ph)
            sar_pkg::ST_IDLE, sar_pkg::ST_ACQ:
            begin
                if (s_q.ph == sar_pkg::ST_ACQ)
                    s_d.cnt = s_q.cnt + 8'h01;
                // power-down only honoured between conversions
                s_d.o.analog_on = ~cfg.power_down_input & (cfg.speed_mode != sar_pkg::SPD_IMPULSE);
                if (start || (s_q.ph == sar_pkg::ST_ACQ && s_q.cnt == sar_pkg::ACQ_CYCLES))
                begin
                    s_d.ph = sar_pkg::ST_CONV;
                    s_d.cnt = 8'h00;
                    s_d.o.busy = 1'b1;
                    s_d.o.analog_on = 1'b1;
                end
                else if (s_q.ph == sar_pkg::ST_ACQ && convert_start_n)
                    s_d.ph = sar_pkg::ST_IDLE;
            end
            sar_pkg::ST_CONV:
            begin
                // starts and power-down are not looked at here
                s_d.cnt = s_q.cnt + 8'h01;
                if (s_q.cnt == sar_pkg::CONV_CYCLES)
                    conv_done = 1'b1;
            end
            sar_pkg::ST_TAIL:
            begin
                if (!s_q.sending)
                begin
                    s_d.o.busy = 1'b0;
                    s_d.ph = sar_pkg::ST_IDLE;
                end
            end
            default: s_d.ph = sar_pkg::ST_IDLE;
        endcase

        if (conv_done)
        begin
            // slave read-during: previous result partly but not fully shifted
            if (serial && cfg.clock_source_select && cfg.read_timing_or_chain_in
                && s_q.bits != 5'h00 && s_q.bits <= sar_pkg::BITS_LAST)
                s_d.o.read_overrun_flag = 1'b1;
            s_d.result = coded;
            s_d.o.analog_on = cfg.speed_mode != sar_pkg::SPD_IMPULSE;
            if (!(master && !cfg.read_timing_or_chain_in))
                s_d.shreg = coded;
            s_d.bits = 5'h00;
            if (master && !cfg.read_timing_or_chain_in)
            begin
                s_d.shreg = coded;
                s_d.sending = 1'b1;
                s_d.ph = sar_pkg::ST_TAIL;
            end
            else
            begin
                s_d.o.busy = 1'b0;
                // self-repeat only in impulse mode
                if (!convert_start_n && cfg.speed_mode == sar_pkg::SPD_IMPULSE)
                begin
                    s_d.ph = sar_pkg::ST_ACQ;
                    s_d.cnt = 8'h00;
                end
                else
                    s_d.ph = sar_pkg::ST_IDLE;
            end
        end
        // master read-during: send previous result from convert-start, within the first half only at divider 0
        if (master && cfg.read_timing_or_chain_in && start && s_q.ph != sar_pkg::ST_CONV)
        begin
            s_d.shreg = s_q.result;
            s_d.sending = 1'b1;
            s_d.bits = 5'h00;
        end

        // internal clock generator with divider
        if (master && s_q.sending)
        begin
            s_d.div = s_q.div + 4'h1;
            if (s_q.div >= {2'b00, cfg.serial_clock_divider} * 4'h3)
            begin
                s_d.div = 4'h0;
                s_d.sclk_int = ~s_q.sclk_int;
                // shift on falling edge so data is stable over the rising one
                if (s_q.sclk_int)
                begin
                    s_d.shreg = {s_q.shreg[16:0], 1'b0};
                    s_d.bits = s_q.bits + 5'h01;
                    if (s_q.bits == sar_pkg::BITS_LAST)
                        s_d.sending = 1'b0;
                end
            end
        end
        else
        begin
            s_d.sclk_int = 1'b0;
            s_d.div = 4'h0;
        end

        // slave clock: chain bit taken on rise, shifted out on fall
        if (serial && cfg.clock_source_select)
        begin
            if (ext_rise && cfg.read_timing_or_chain_in)
                s_d.chain_bit = cfg.read_timing_or_chain_in;
            if (ext_rise)
                s_d.chain_bit = cfg.read_timing_or_chain_in;
            if (ext_fall && s_q.bits <= sar_pkg::BITS_LAST)
            begin
                s_d.shreg = {s_q.shreg[16:0], s_q.chain_bit};
                s_d.bits = s_q.bits + 5'h01;
            end
        end

        // output drivers
        s_d.o.sclk_out = s_d.sclk_int ^ cfg.invert_sclk;
        s_d.o.sclk_oe = master & rd_on;
        s_d.o.sync_out = s_d.sending ^ cfg.invert_sync;
        s_d.o.data_out = 18'h00000;
        s_d.o.data_oe = 18'h00000;
        if (rd_on)
        begin
            unique case (bm)
                sar_pkg::BUS_18: begin s_d.o.data_out = s_q.result; s_d.o.data_oe = 18'h3ffff; end
                sar_pkg::BUS_16:
                begin
                    s_d.o.data_out = cfg.byte_sel ? {16'h0000, s_q.result[1:0]} : {2'b00, s_q.result[17:2]};
                    s_d.o.data_oe = 18'h0ffff;
                end
                sar_pkg::BUS_8:
                begin
                    s_d.o.data_out = cfg.byte_sel ? {10'h000, s_q.result[9:2]} : {10'h000, s_q.result[17:10]};
                    s_d.o.data_oe = 18'h000ff;
                end
                sar_pkg::BUS_SERIAL:
                begin
                    s_d.o.data_out = {17'h00000, s_d.shreg[17]};
                    s_d.o.data_oe = 18'h00001;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.cnv_prev <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign out = s_q.o;

    property p_busy_rise;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.ph == sar_pkg::ST_IDLE && $fell(convert_start_n) && s_q.cnv_prev) |=> out.busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");

    property p_hiz;
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_n || rd_n) |=> (out.data_oe == 18'h00000);
    endproperty
    a_hiz: assert property (p_hiz) else $error("outputs driven while deselected");

    property p_no_restart;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.ph == sar_pkg::ST_CONV && s_q.cnt != sar_pkg::CONV_CYCLES) |=> s_q.ph == sar_pkg::ST_CONV;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion aborted");

    property p_tail_busy;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.ph == sar_pkg::ST_TAIL && s_q.sending) |-> out.busy;
    endproperty
    a_tail_busy: assert property (p_tail_busy) else $error("busy fell before bits sent");

    property p_refbuf;
        @(posedge clk_sys) disable iff (!rst_n)
        cfg.ref_buffer_powerdown |=> !out.ref_buf_on;
    endproperty
    a_refbuf: assert property (p_refbuf) else $error("ref buffer on while powered down");

    property p_repeat;
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.ph == sar_pkg::ST_ACQ) |-> cfg.speed_mode == sar_pkg::SPD_IMPULSE || $past(cfg.speed_mode) == sar_pkg::SPD_IMPULSE;
    endproperty
    a_repeat: assert property (p_repeat) else $error("self repeat outside impulse mode");

    property p_overrun_pulse;
        @(posedge clk_sys) disable iff (!rst_n)
        out.read_overrun_flag |=> !out.read_overrun_flag;
    endproperty
    a_overrun_pulse: assert property (p_overrun_pulse) else $error("overrun not a pulse");

    property p_bits;
        @(posedge clk_sys) disable iff (!rst_n)
        s_q.bits <= 5'h12;
    endproperty
    a_bits: assert property (p_bits) else $error("more than 18 bits shifted");
endmodule

/* File: common/sar_pkg.sv */
// shared constants and carriers for the converter sequencing and readout block
// ----------------------------------------------------------------
// Notes on behaviour
// - ref buffer powered down while its powerdown input is high
// - impulse mode cuts current after each conversion; interface stays active
// - convert-start begins conversion; further starts and power-down ignored until done
// - convert-start works regardless of chip-select and read
// - impulse mode: start held low at busy fall times acquisition, reconverts; code skips this after a master read-after
// - self-repeat only in impulse mode, never warp or normal
// - coding select applies in all interface modes except 18-bit parallel
// - outputs high impedance unless chip-select and read both low
// - parallel bus width 18, 16 or 8 bits by mode inputs
// - result readable in next acquisition or during following conversion
// - both mode select inputs high selects serial interface
// - serial shifts 18 bits msb first, one per clock pulse
// - serial data shifts on the falling clock edge, stable across the rising one
// - clock source low: device makes serial clock and sync, optionally inverted
// - master mode: read-timing input picks after-conversion or during-next
// - master read-after: busy stays high until all 18 bits sent
// - divider inputs slow the internal serial clock
// - clock source high: external clock, shift only with chip-select and read low
// - external clock may be continuous or gapped, idling high or low
// - slave read-during: unread bits at conversion end pulse read-overrun; code pulses only once a read has begun
// - slave read-after daisy chain latches chain input on opposite edge
// ----------------------------------------------------------------
package sar_pkg;
    localparam int RES_W = 18;
    localparam logic [4:0] BITS_LAST = 5'h11;
    localparam logic [7:0] CONV_CYCLES = 8'h8c;   // about 700 ns at 200 MHz
    localparam logic [7:0] ACQ_CYCLES = 8'h5a;    // self-timed acquisition
    localparam logic [7:0] HALF_CONV = 8'h46;
    localparam logic [1:0] SPD_IMPULSE = 2'h2;
    localparam logic [1:0] BUS_18 = 2'h0;
    localparam logic [1:0] BUS_16 = 2'h1;
    localparam logic [1:0] BUS_8 = 2'h2;
    localparam logic [1:0] BUS_SERIAL = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_TAIL, ST_ACQ} phase_e;

    typedef struct packed {
        logic       ref_buffer_powerdown;
        logic       power_down_input;
        logic [1:0] speed_mode;
        logic       output_coding_select;
        logic       interface_mode_sel_lo;
        logic       interface_mode_sel_hi;
        logic       clock_source_select;
        logic       read_timing_or_chain_in;
        logic [1:0] serial_clock_divider;
        logic       invert_sclk;
        logic       invert_sync;
        logic       byte_sel;
    } cfg_s;

    typedef struct packed {
        logic [17:0] data_out;
        logic [17:0] data_oe;
        logic        sclk_out;
        logic        sclk_oe;
        logic        sync_out;
        logic        busy;
        logic        read_overrun_flag;
        logic        ref_buf_on;
        logic        analog_on;
    } out_s;
endpackage

/* File: bench/host_reader.sv */
// host side model: clocks one 18-bit slave serial read and gathers the word
`timescale 1ns/1ps
module host_reader (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic        sdo,
    output logic             sclk,
    output logic [17:0]      word,
    output logic             done
);
    initial
    begin
        sclk = 1'b0;
        word = 18'h0;
        done = 1'b0;
        forever
        begin
            @(negedge clk_sys);
            if (go && !done)
            begin
                // slow half period, well under the clk/4 sampling limit
                for (int b = 0; b < 18; b++)
                begin
                    sclk = 1'b1;
                    repeat (8) @(negedge clk_sys);
                    word = {word[16:0], sdo};
                    sclk = 1'b0;
                    repeat (8) @(negedge clk_sys);
                end
                done = 1'b1;
            end
            else if (!go)
            begin
                done = 1'b0;
            end
        end
    end
endmodule

/* File: bench/sar_adc_conversion_and_readout_tb_top.sv */
// self-checking bench for the conversion sequencer and readout
`timescale 1ns/1ps
module sar_adc_conversion_and_readout_tb_top;
    logic          clk_sys = 1'b0;
    logic          rst_n = 1'b0;
    logic          convert_start_n = 1'b1;
    logic          cs_n = 1'b1;
    logic          rd_n = 1'b1;
    logic          go = 1'b0;
    sar_pkg::cfg_s cfg = '0;
    logic [17:0]   sample_code = 18'h0;
    sar_pkg::out_s out;
    logic          sclk;
    logic [17:0]   word;
    logic          done;
    logic [17:0]   e;
    int            num_errors = 0;
    int            check_count = 0;
    int            seed = 32'h7a52bf13;
    int            n;
    int            lo;
    int            ovr_cnt = 0;
    int            sclk_rises = 0;
    int            m0;
    logic          sclk_d = 1'b0;

    always #2.5 clk_sys = ~clk_sys;

    // monitors look on the falling edge, where registered outputs have settled
    always @(negedge clk_sys)
    begin
        if (out.read_overrun_flag === 1'b1)
            ovr_cnt = ovr_cnt + 1;
        if (out.sclk_out === 1'b1 && sclk_d === 1'b0)
            sclk_rises = sclk_rises + 1;
        sclk_d = out.sclk_out;
    end

    sar_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .convert_start_n(convert_start_n), .cs_n(cs_n),
                    .rd_n(rd_n), .sclk_in(sclk), .cfg(cfg), .sample_code(sample_code), .out(out));
    host_reader host_u (.clk_sys(clk_sys), .go(go), .sdo(out.data_out[0]), .sclk(sclk), .word(word),
                        .done(done));

    function automatic logic [17:0] coded(input logic [17:0] c);
        // twos complement is msb inversion; 18-bit bus ignores coding
        if (cfg.output_coding_select || {cfg.interface_mode_sel_hi, cfg.interface_mode_sel_lo} == sar_pkg::BUS_18)
            return c;
        return c ^ 18'h20000;
    endfunction

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_busy(input logic lvl, input int lim, output int k);
        k = 0;
        while (out.busy !== lvl)
        begin
            @(negedge clk_sys);
            k++;
            if (k > lim)
            begin
                num_errors++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, k, lim);
                end_of_test();
            end
        end
    endtask

    // again: a second start in mid-conversion, which must not stretch busy
    task automatic convert(input logic again, output int len);
        int k;
        sample_code = 18'($random(seed));
        convert_start_n = 1'b0;
        wait_busy(1'b1, 6, k);
        chk(18'(k >= 1 && k <= 3), 18'h1);
        convert_start_n = 1'b1;
        len = 0;
        if (again)
        begin
            repeat (20) @(negedge clk_sys);
            convert_start_n = 1'b0;
            repeat (3) @(negedge clk_sys);
            convert_start_n = 1'b1;
            len = 23;
        end
        wait_busy(1'b0, 3000, k);
        len = len + k;
    endtask

    initial
    begin
        lo = int'(sar_pkg::CONV_CYCLES);
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(out.data_oe, 18'h0);
        for (int p = 0; p < 2; p++)
        begin
            cfg.ref_buffer_powerdown = p[0];
            repeat (3) @(negedge clk_sys);
            chk({17'h0, out.ref_buf_on}, {17'h0, ~p[0]});
        end
        // parallel widths with both codings, busy width and strobe gating
        for (int i = 0; i < 6; i++)
        begin
            {cfg.interface_mode_sel_hi, cfg.interface_mode_sel_lo} = 2'(i % 3);
            cfg.output_coding_select = i[0];
            cfg.byte_sel = 1'($random(seed));
            convert(1'(i == 2), n);
            chk(18'(n >= lo && n <= lo + 6), 18'h1);
            e = coded(sample_code);
            cs_n = 1'b0;
            rd_n = 1'b0;
            repeat (3) @(negedge clk_sys);
            if (i % 3 == 0)
                chk(out.data_out, e);
            else if (i % 3 == 1)
                chk({2'h0, out.data_out[15:0]}, cfg.byte_sel ? {16'h0, e[1:0]} : {2'h0, e[17:2]});
            else
                chk({10'h0, out.data_out[7:0]}, {10'h0, cfg.byte_sel ? e[9:2] : e[17:10]});
            rd_n = 1'b1;
            repeat (3) @(negedge clk_sys);
            chk(out.data_oe, 18'h0);
            cs_n = 1'b1;
        end
        // parallel read in the first half of the next conversion still sees the old result
        sample_code = ~sample_code;
        convert_start_n = 1'b0;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk({10'h0, out.data_out[7:0]}, {10'h0, cfg.byte_sel ? e[9:2] : e[17:10]});
        cs_n = 1'b1;
        rd_n = 1'b1;
        convert_start_n = 1'b1;
        wait_busy(1'b0, 3000, n);
        // slave serial read after conversion, start repeated mid-conversion
        cfg = '0;
        {cfg.interface_mode_sel_hi, cfg.interface_mode_sel_lo, cfg.clock_source_select} = 3'h7;
        convert(1'b1, n);
        chk(18'(n >= lo && n <= lo + 6), 18'h1);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        go = 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 600)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk({17'h0, done}, 18'h1);
        chk(word, coded(sample_code));
        go = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        // master read after conversion keeps busy through the 18 bits
        cfg.clock_source_select = 1'b0;
        cs_n = 1'b0;
        rd_n = 1'b0;
        m0 = sclk_rises;
        convert(1'b0, n);
        chk(18'(n > lo + 36), 18'h1);
        chk(18'(sclk_rises - m0), 18'h12);
        chk({17'h0, out.sync_out}, 18'h0);
        cs_n = 1'b1;
        rd_n = 1'b1;
        // impulse mode repeats while start stays low; normal mode does not
        for (int s = 0; s < 2; s++)
        begin
            cfg.speed_mode = s ? 2'h0 : sar_pkg::SPD_IMPULSE;
            cfg.interface_mode_sel_hi = 1'b0;
            repeat (4) @(negedge clk_sys);
            convert_start_n = 1'b0;
            wait_busy(1'b1, 6, n);
            wait_busy(1'b0, 3000, n);
            chk({17'h0, out.analog_on}, {17'h0, 1'(s)});
            if (s == 0)
                wait_busy(1'b1, int'(sar_pkg::ACQ_CYCLES) + 10, n);
            else
            begin
                repeat (200) @(negedge clk_sys);
                chk({17'h0, out.busy}, 18'h0);
            end
            convert_start_n = 1'b1;
            wait_busy(1'b0, 3000, n);
        end
        // no read-during slave run here, so an overrun pulse would be spurious
        chk(18'(ovr_cnt), 18'h0);
        end_of_test();
    end
endmodule
